/* diag_pkg.sv */
package diag_pkg;

   localparam int          NUM_CH      = 5;
   localparam int          NUM_LED_CH  = 3;
   localparam logic [3:0]  FRAME_BITS  = 4'h8;
   localparam logic [3:0]  LAST_BIT    = 4'h7;
   localparam logic [3:0]  CLR_EDGE    = 4'h1;

   // Frame byte layout
   localparam int          CMD_WR_POS  = 7;
   localparam int          CMD_IDX_HI  = 6;
   localparam int          CMD_IDX_LO  = 5;
   localparam int          CMD_DAT_HI  = 4;

   // Register indices
   localparam logic [1:0]  IDX_HWCFG   = 2'h0;
   localparam logic [1:0]  IDX_SENSE   = 2'h1;
   localparam logic [1:0]  IDX_LOAD    = 2'h2;
   localparam logic [1:0]  IDX_OUT     = 2'h3;

   // hardware_config fields
   localparam int          HW_CTL_POS  = 0;
   localparam int          HW_PWM_POS  = 1;
   localparam int          HW_SBM_POS  = 2;
   localparam int          HW_WDL_POS  = 3;
   localparam int          HW_LHO_POS  = 4;

   // Reset values
   localparam logic [2:0]  SENSE_OFF   = 3'h7;
   localparam logic [2:0]  LOAD_RST    = 3'h0;
   localparam logic [4:0]  OUT_RST     = 5'h00;

   typedef struct packed {
      logic [6:0] rx;
      logic [7:0] rx_byte;
      logic       e2_tgl;
      logic       dn_tgl;
      logic       miso;
   } link_s;

   typedef struct packed {
      logic       cs_s1, cs_s2;
      logic [4:0] ovl_s1, ovl_s2;
      logic [4:0] ot_s1, ot_s2;
      logic [4:0] vds_s1, vds_s2;
      logic       lho_s1, lho_s2;
      logic       e2_s1, e2_s2, e2_s3;
      logic       dn_s1, dn_s2, dn_s3;
      logic [4:0] th;
      logic [4:0] ot_err;
      logic [4:0] ovl_lat;
      logic       ctl_pend;
      logic       rd_valid;
      logic [1:0] rd_idx;
      logic [7:0] reply;
      logic       watchdog_level_bit;
      logic       pwm;
      logic [2:0] sense_sel;
      logic [2:0] load_cfg;
      logic [4:0] out_cmd;
      logic [4:0] gate_on;
      logic [4:0] sense_en;
      logic [2:0] sense_led;
      logic       bypass;
   } core_s;

endpackage

/* power_switch_diagnosis_logic.sv */
`timescale 1ns/1ps
module power_switch_diagnosis_logic (
   input  wire logic       clk_i,
   input  wire logic       nrst_i,
   input  wire logic       sclk_i,
   input  wire logic       cs_n_i,
   input  wire logic       mosi_i,
   output logic            miso_o,
   input  wire logic [4:0] overload_i,
   input  wire logic [4:0] over_temp_i,
   input  wire logic [4:0] vds_low_i,
   input  wire logic       limp_home_status_i,
   output logic      [4:0] gate_on_o,
   output logic      [4:0] sense_en_o,
   output logic      [2:0] load_type_select_o,
   output logic            bypass_monitor_result_o
);

   diag_pkg::link_s lk_q, lk_d;
   diag_pkg::core_s cr_q, cr_d;
   logic      [3:0] cnt_q;
   logic            frame_rst_n;

   // Link side: counter restarts with every frame
   assign frame_rst_n = nrst_i & ~cs_n_i;

   always_ff @(posedge sclk_i or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         cnt_q <= 4'h0;
      end else if (cnt_q < diag_pkg::FRAME_BITS) begin
         cnt_q <= cnt_q + 4'h1;
      end
   end

   always_comb begin
      lk_d = lk_q;
      if (cnt_q < diag_pkg::FRAME_BITS) begin
         lk_d.rx = {lk_q.rx[5:0], mosi_i};
         // Reply is frozen by the core while a frame runs
         lk_d.miso = cr_q.reply[3'(diag_pkg::LAST_BIT - cnt_q)];
      end else begin
         lk_d.miso = 1'b0;
      end
      if (cnt_q == diag_pkg::CLR_EDGE) begin
         lk_d.e2_tgl = ~lk_q.e2_tgl;
      end
      if (cnt_q == diag_pkg::LAST_BIT) begin
         lk_d.rx_byte = {lk_q.rx, mosi_i};
         lk_d.dn_tgl  = ~lk_q.dn_tgl;
      end
   end

   always_ff @(posedge sclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         lk_q <= '0;
      end else begin
         lk_q <= lk_d;
      end
   end

   // Core side
   logic       e2_ev;
   logic       dn_ev;
   logic       wr_ev;
   logic       ctl_cmd;
   logic [1:0] cmd_idx;
   logic [4:0] cmd_dat;
   logic [4:0] err;
   logic [4:0] hw_rd;

   always_comb begin
      cr_d = cr_q;
      // Two-stage synchronisers, first stage read only by the second
      cr_d.cs_s1  = cs_n_i;
      cr_d.cs_s2  = cr_q.cs_s1;
      cr_d.ovl_s1 = overload_i;
      cr_d.ovl_s2 = cr_q.ovl_s1;
      cr_d.ot_s1  = over_temp_i;
      cr_d.ot_s2  = cr_q.ot_s1;
      cr_d.vds_s1 = vds_low_i;
      cr_d.vds_s2 = cr_q.vds_s1;
      cr_d.lho_s1 = limp_home_status_i;
      cr_d.lho_s2 = cr_q.lho_s1;
      cr_d.e2_s1  = lk_q.e2_tgl;
      cr_d.e2_s2  = cr_q.e2_s1;
      cr_d.e2_s3  = cr_q.e2_s2;
      cr_d.dn_s1  = lk_q.dn_tgl;
      cr_d.dn_s2  = cr_q.dn_s1;
      cr_d.dn_s3  = cr_q.dn_s2;

      e2_ev   = cr_q.e2_s2 ^ cr_q.e2_s3;
      dn_ev   = cr_q.dn_s2 ^ cr_q.dn_s3;
      // Received byte is stable long after its toggle
      cmd_idx = lk_q.rx_byte[diag_pkg::CMD_IDX_HI:diag_pkg::CMD_IDX_LO];
      cmd_dat = lk_q.rx_byte[diag_pkg::CMD_DAT_HI:0];
      wr_ev   = dn_ev & lk_q.rx_byte[diag_pkg::CMD_WR_POS];
      ctl_cmd = wr_ev & (cmd_idx == diag_pkg::IDX_HWCFG) & cmd_dat[diag_pkg::HW_CTL_POS];

      // Thermal latch, new event wins over the clear
      cr_d.th = (cr_q.th & ~{5{ctl_cmd}}) | cr_q.ot_s2;

      // Second thermal copy in the error flag, cleared one frame late
      cr_d.ot_err = cr_q.ot_err | cr_q.th;
      if (ctl_cmd) begin
         cr_d.ctl_pend = 1'b1;
      end else if (e2_ev && cr_q.ctl_pend) begin
         cr_d.ctl_pend = 1'b0;
         cr_d.ot_err   = cr_q.th;
      end

      // Overload flag clears only in a diagnosis frame, set wins
      if (e2_ev && !cr_q.rd_valid) begin
         cr_d.ovl_lat = cr_q.ovl_s2;
      end else begin
         cr_d.ovl_lat = cr_q.ovl_lat | cr_q.ovl_s2;
      end

      if (dn_ev) begin
         cr_d.rd_valid = ~lk_q.rx_byte[diag_pkg::CMD_WR_POS];
         cr_d.rd_idx   = cmd_idx;
      end
      if (wr_ev) begin
         unique case (cmd_idx)
            diag_pkg::IDX_HWCFG: begin
               cr_d.watchdog_level_bit = cmd_dat[diag_pkg::HW_WDL_POS];
               cr_d.pwm = cmd_dat[diag_pkg::HW_PWM_POS];
            end
            diag_pkg::IDX_SENSE: cr_d.sense_sel = cmd_dat[2:0];
            diag_pkg::IDX_LOAD:  cr_d.load_cfg  = cmd_dat[2:0];
            diag_pkg::IDX_OUT:   cr_d.out_cmd   = cmd_dat;
         endcase
      end

      err   = cr_q.ot_err | cr_q.ovl_lat;
      hw_rd = {cr_q.lho_s2, cr_q.watchdog_level_bit, cr_q.bypass, cr_q.pwm, 1'b0};
      // Reply only moves between frames so the link sees a steady word
      if (cr_q.cs_s2) begin
         if (!cr_q.rd_valid) begin
            cr_d.reply = {3'h0, err};
         end else begin
            unique case (cr_q.rd_idx)
               diag_pkg::IDX_HWCFG: cr_d.reply = {3'h0, hw_rd};
               diag_pkg::IDX_SENSE: cr_d.reply = {5'h00, cr_q.sense_sel};
               diag_pkg::IDX_LOAD:  cr_d.reply = {5'h00, cr_q.load_cfg};
               diag_pkg::IDX_OUT:   cr_d.reply = {3'h0, cr_q.out_cmd};
            endcase
         end
      end

      cr_d.gate_on = cr_q.out_cmd & ~cr_q.th;
      for (int i = 0; i < diag_pkg::NUM_CH; i++) begin
         cr_d.sense_en[i] = (cr_q.sense_sel == 3'(i))
                            & ~cr_q.ovl_s2[i] & ~cr_q.th[i];
      end
      cr_d.sense_led = cr_q.load_cfg;
      if (cr_q.sense_sel < 3'(diag_pkg::NUM_CH)) begin
         cr_d.bypass = cr_q.vds_s2[cr_q.sense_sel];
      end else begin
         cr_d.bypass = 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cr_q           <= '0;
         cr_q.cs_s1     <= 1'b1;
         cr_q.cs_s2     <= 1'b1;
         cr_q.sense_sel <= diag_pkg::SENSE_OFF;
         cr_q.load_cfg  <= diag_pkg::LOAD_RST;
         cr_q.out_cmd   <= diag_pkg::OUT_RST;
      end else begin
         cr_q <= cr_d;
      end
   end

   assign miso_o                  = lk_q.miso;
   assign gate_on_o               = cr_q.gate_on;
   assign sense_en_o              = cr_q.sense_en;
   assign load_type_select_o      = cr_q.sense_led;
   assign bypass_monitor_result_o = cr_q.bypass;

   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);

   sequence s_clear_cmd;
      ctl_cmd && cr_q.ot_s2 == 5'h00;
   endsequence

   sequence s_clear_frame;
      e2_ev && cr_q.ctl_pend && cr_q.th == 5'h00;
   endsequence

   a_thermal_clear_all: assert property (s_clear_cmd |=> cr_q.th == 5'h00)
      else $error("thermal latch not cleared");
   a_thermal_clear_keep: assert property (dn_ev && !ctl_cmd
      |=> (cr_q.th & $past(cr_q.th)) == $past(cr_q.th))
      else $error("thermal latch lost without clear");
   a_diag_word_err: assert property (cr_q.cs_s2 && !cr_q.rd_valid
      |=> cr_q.reply == {3'h0, $past(cr_q.ot_err | cr_q.ovl_lat)})
      else $error("diagnosis word mismatch");
   a_ovl_frame_clear: assert property (e2_ev && !cr_q.rd_valid
      && cr_q.ovl_s2 == 5'h00 |=> cr_q.ovl_lat == 5'h00)
      else $error("overload flag not cleared");
   a_ovl_flag_held: assert property (!e2_ev
      |=> (cr_q.ovl_lat & $past(cr_q.ovl_lat)) == $past(cr_q.ovl_lat))
      else $error("overload flag dropped early");
   a_gate_thermal_off: assert property ((cr_q.gate_on & $past(cr_q.th)) == 5'h00)
      else $error("gate on while latched hot");
   a_ot_err_frame: assert property (s_clear_frame |=> cr_q.ot_err == 5'h00)
      else $error("thermal error flag not cleared");
   a_ot_err_first_word: assert property (s_clear_cmd ##1 !e2_ev
      |-> (cr_q.ot_err & $past(cr_q.ot_err, 2)) == $past(cr_q.ot_err, 2))
      else $error("thermal error lost before next frame");
   a_ovl_reassert: assert property (e2_ev && cr_q.ovl_s2 != 5'h00
      |=> (cr_q.ovl_lat & $past(cr_q.ovl_s2)) == $past(cr_q.ovl_s2))
      else $error("persisting overload not flagged");
   a_sense_single: assert property ($onehot0(cr_q.sense_en))
      else $error("more than one sense channel");
   a_sense_disabled: assert property (cr_q.sense_sel >= 3'(diag_pkg::NUM_CH)
      |=> cr_q.sense_en == 5'h00)
      else $error("sense on while disabled");
   a_sense_fault_off: assert property (1'b1
      |=> (cr_q.sense_en & $past(cr_q.ovl_s2 | cr_q.th)) == 5'h00)
      else $error("sense on during fault");
   a_load_type_out: assert property (##1 cr_q.sense_led == $past(cr_q.load_cfg))
      else $error("load type not applied");
   a_bypass_result: assert property (cr_q.sense_sel < 3'(diag_pkg::NUM_CH)
      |=> cr_q.bypass == $past(cr_q.vds_s2[cr_q.sense_sel]))
      else $error("bypass result mismatch");
   a_sync_latency: assert property ((cr_q.ovl_s1 & ~cr_q.ovl_s2) != 5'h00
      |-> ##2 (cr_q.ovl_lat & $past(cr_q.ovl_s1 & ~cr_q.ovl_s2, 2))
      == $past(cr_q.ovl_s1 & ~cr_q.ovl_s2, 2))
      else $error("overload not latched after sync");

   // Reply kinds, taken while the link is idle
   sequence s_diag_reply;
      cr_q.cs_s2 && !cr_q.rd_valid;
   endsequence

   sequence s_read_reply;
      cr_q.cs_s2 && cr_q.rd_valid;
   endsequence

   // Thermal latch and gate control
   a_th_hold_no_clear: assert property (!ctl_cmd
      |=> (cr_q.th & $past(cr_q.th)) == $past(cr_q.th))
      else $error("thermal latch dropped");
   a_th_set_event: assert property (cr_q.ot_s2 != 5'h00
      |=> (cr_q.th & $past(cr_q.ot_s2)) == $past(cr_q.ot_s2))
      else $error("thermal event not latched");
   a_th_set_wins: assert property (ctl_cmd && cr_q.ot_s2 != 5'h00
      |=> (cr_q.th & $past(cr_q.ot_s2)) == $past(cr_q.ot_s2))
      else $error("clear beat a live thermal event");
   a_th_stay_clear: assert property (cr_q.th == 5'h00 && cr_q.ot_s2 == 5'h00
      |=> cr_q.th == 5'h00)
      else $error("thermal latch set without event");
   a_gate_off_cmd: assert property (##1
      (cr_q.gate_on & ~$past(cr_q.out_cmd)) == 5'h00)
      else $error("gate on without command");
   a_out_cmd_hold: assert property (!wr_ev
      |=> $stable(cr_q.out_cmd))
      else $error("output command moved without write");

   // Error flags
   a_ot_err_holds_th: assert property (##1
      (cr_q.ot_err & $past(cr_q.th)) == $past(cr_q.th))
      else $error("thermal latch missing from error flag");
   a_ovl_lat_has_s2: assert property (##1
      (cr_q.ovl_lat & $past(cr_q.ovl_s2)) == $past(cr_q.ovl_s2))
      else $error("live overload missing from error flag");
   a_ovl_keep_read: assert property (e2_ev && cr_q.rd_valid
      |=> (cr_q.ovl_lat & $past(cr_q.ovl_lat)) == $past(cr_q.ovl_lat))
      else $error("overload flag cleared in read frame");
   a_ctl_pend_set: assert property (ctl_cmd
      |=> cr_q.ctl_pend)
      else $error("clear command not pending");
   a_ctl_pend_done: assert property (e2_ev && cr_q.ctl_pend && !ctl_cmd
      |=> !cr_q.ctl_pend)
      else $error("pending clear not consumed");
   a_ot_err_no_pend: assert property (!cr_q.ctl_pend
      |=> (cr_q.ot_err & $past(cr_q.ot_err)) == $past(cr_q.ot_err))
      else $error("thermal error flag lost without clear");

   // Reply word
   a_reply_frozen: assert property (!cr_q.cs_s2
      |=> $stable(cr_q.reply))
      else $error("reply moved during frame");
   a_diag_word_top: assert property (s_diag_reply
      |=> cr_q.reply[7:5] == 3'h0)
      else $error("diagnosis word upper bits set");
   a_hw_read_word: assert property (s_read_reply ##0
      cr_q.rd_idx == diag_pkg::IDX_HWCFG
      |=> cr_q.reply[0] == 1'b0 && cr_q.reply[2] == $past(cr_q.bypass))
      else $error("hardware config readback mismatch");
   a_read_sense_word: assert property (s_read_reply ##0
      cr_q.rd_idx == diag_pkg::IDX_SENSE
      |=> cr_q.reply == {5'h00, $past(cr_q.sense_sel)})
      else $error("sense select readback mismatch");
   a_read_load_word: assert property (s_read_reply ##0
      cr_q.rd_idx == diag_pkg::IDX_LOAD
      |=> cr_q.reply == {5'h00, $past(cr_q.load_cfg)})
      else $error("load config readback mismatch");

   // Sense path, load type and bypass compare
   a_sense_sel_match: assert property (1'b1
      |=> (cr_q.sense_en & ~(5'h01 << $past(cr_q.sense_sel))) == 5'h00)
      else $error("sense on for unselected channel");
   a_sense_on_healthy: assert property (cr_q.sense_sel == 3'h0
      && !cr_q.ovl_s2[0] && !cr_q.th[0]
      |=> cr_q.sense_en[0])
      else $error("healthy selected channel not sensed");
   a_sense_sel_hold: assert property (!wr_ev
      |=> $stable(cr_q.sense_sel))
      else $error("sense select moved without write");
   a_sense_th_off: assert property (cr_q.th != 5'h00
      |=> (cr_q.sense_en & $past(cr_q.th)) == 5'h00)
      else $error("sense on for hot channel");
   a_bypass_off: assert property (cr_q.sense_sel >= 3'(diag_pkg::NUM_CH)
      |=> !cr_q.bypass)
      else $error("bypass result while sense disabled");
   a_sense_led_hold: assert property (!wr_ev
      |-> ##2 $stable(cr_q.sense_led))
      else $error("load type moved without write");
   a_load_cfg_width: assert property (##1
      cr_q.sense_led == $past(cr_q.load_cfg))
      else $error("load type output lags config");

   // Synchronisers feed only their second stage
   a_ovl_sync: assert property (##1 cr_q.ovl_s2 == $past(cr_q.ovl_s1))
      else $error("overload sync stage broken");
   a_ot_sync: assert property (##1 cr_q.ot_s2 == $past(cr_q.ot_s1))
      else $error("thermal sync stage broken");
   a_vds_sync: assert property (##1 cr_q.vds_s2 == $past(cr_q.vds_s1))
      else $error("bypass sync stage broken");

endmodule

/* spi_master_model.sv */
`timescale 1ns/1ps
module spi_master_model (
   output logic            sclk_o,
   output logic            cs_n_o,
   output logic            mosi_o,
   input  wire logic       miso_i,
   output logic      [7:0] rx_o,
   output logic            done_o
);
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      mosi_o = 1'b0;
      rx_o   = 8'h00;
      done_o = 1'b0;
   end

   // Byte is write/index/data; index 0 bit 0 set clears thermal latches
   // Index 2 carries the load type bits of channels 0 to 2
   task automatic xfer(input logic [7:0] tx);
      logic [7:0] rx;
      rx = 8'h00;
      cs_n_o = 1'b0;
      #21;
      for (int k = 7; k >= 0; k--) begin
         mosi_o = tx[k];
         #3 sclk_o = 1'b1;
         #3 sclk_o = 1'b0;
         rx[k] = miso_i;
      end
      #3 cs_n_o = 1'b1;
      // Released line shows a flipped level, not a stale bit
      mosi_o = ~mosi_o;
      rx_o = rx;
      done_o = 1'b1;
      #1 done_o = 1'b0;
      // Long idle gap lets the core apply the command and load the next reply
      #60;
   endtask
endmodule

/* tb_power_switch_diagnosis_logic.sv */
`timescale 1ns/1ps
module tb_power_switch_diagnosis_logic;
   logic       clk_i;
   logic       nrst_i;
   logic       sclk, cs_n, mosi, miso, spi_done;
   logic [7:0] spi_rx;
   logic [4:0] overload_i, over_temp_i, vds_low_i, gate_on, sense_en;
   logic       lho_i, bypass;
   logic [2:0] load_type;
   logic [7:0] exp_q[$];
   logic [31:0] seed = 32'h988790f5;
   logic [31:0] rnd;
   int         n_errors = 0;
   int         total_checks = 0;
   int         cycles = 0;

   power_switch_diagnosis_logic power_switch_diagnosis_logic_i (
      .clk_i(clk_i), .nrst_i(nrst_i), .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi),
      .miso_o(miso), .overload_i(overload_i), .over_temp_i(over_temp_i),
      .vds_low_i(vds_low_i), .limp_home_status_i(lho_i), .gate_on_o(gate_on),
      .sense_en_o(sense_en), .load_type_select_o(load_type),
      .bypass_monitor_result_o(bypass));

   spi_master_model spi_master_model_i (
      .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso),
      .rx_o(spi_rx), .done_o(spi_done));

   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function automatic logic [7:0] wr(logic [1:0] idx, logic [4:0] d);
      return {1'b1, idx, d};
   endfunction

   function automatic logic [7:0] rd(logic [1:0] idx);
      return {1'b0, idx, 5'h00};
   endfunction

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic results();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic wclk(input int n);
      repeat (n) @(negedge clk_i);
   endtask

   // Reply expected in the frame is noted before it starts
   task automatic frame(input logic [7:0] tx, input logic [7:0] exp);
      exp_q.push_back(exp);
      spi_master_model_i.xfer(tx);
   endtask

   always @(posedge spi_done) check("reply", spi_rx, exp_q.pop_front());

   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         results();
      end
   end

   initial begin
      nrst_i = 1'b0;
      overload_i = 5'h00;
      over_temp_i = 5'h00;
      vds_low_i = 5'h00;
      lho_i = 1'b0;
      wclk(16);
      nrst_i = 1'b1;
      wclk(4);
      check("gate_rst", {3'h0, gate_on}, 8'h00);
      check("sense_rst", {3'h0, sense_en}, 8'h00);
      frame(rd(diag_pkg::IDX_SENSE), 8'h00);
      for (int p = 0; p < 2; p++) begin
         frame(wr(diag_pkg::IDX_OUT, (p == 0) ? 5'h1f : 5'h00), (p == 0) ? 8'h07 : 8'h00);
         wclk(8);
         check("gate_cmd", {3'h0, gate_on}, (p == 0) ? 8'h1f : 8'h00);
         // Bypass compare must follow the selection whether outputs are on or off
         for (int ch = 0; ch < 5; ch++) begin
            rnd = xs();
            vds_low_i = rnd[4:0];
            frame(wr(diag_pkg::IDX_SENSE, 5'(ch)), 8'h00);
            wclk(8);
            check("bypass", {7'h0, bypass}, {7'h0, rnd[ch]});
            if (p == 0) check("sense_sel", {3'h0, sense_en}, 8'(1 << ch));
         end
      end
      frame(wr(diag_pkg::IDX_SENSE, 5'h07), 8'h00);
      wclk(8);
      check("sense_off", {3'h0, sense_en}, 8'h00);
      check("bypass_off", {7'h0, bypass}, 8'h00);
      rnd = xs();
      frame(wr(diag_pkg::IDX_LOAD, {2'h0, rnd[2:0]}), 8'h00);
      wclk(8);
      check("load_type", {5'h0, load_type}, {5'h0, rnd[2:0]});
      frame(rd(diag_pkg::IDX_LOAD), 8'h00);
      frame(wr(diag_pkg::IDX_OUT, 5'h1f), {5'h0, rnd[2:0]});
      frame(wr(diag_pkg::IDX_SENSE, 5'h01), 8'h00);
      vds_low_i = 5'h00;
      overload_i = 5'h02;
      wclk(6);
      check("sense_fault", {3'h0, sense_en}, 8'h00);
      overload_i = 5'h00;
      wclk(6);
      check("sense_back", {3'h0, sense_en}, 8'h02);
      frame(wr(diag_pkg::IDX_HWCFG, 5'h00), 8'h02);
      frame(wr(diag_pkg::IDX_HWCFG, 5'h00), 8'h00);
      // Persistent overload re-arms its flag after each report
      overload_i = 5'h08;
      wclk(6);
      frame(wr(diag_pkg::IDX_HWCFG, 5'h00), 8'h08);
      frame(wr(diag_pkg::IDX_HWCFG, 5'h00), 8'h08);
      overload_i = 5'h00;
      wclk(6);
      frame(wr(diag_pkg::IDX_HWCFG, 5'h00), 8'h08);
      frame(wr(diag_pkg::IDX_HWCFG, 5'h00), 8'h00);
      over_temp_i = 5'h01;
      wclk(6);
      over_temp_i = 5'h00;
      wclk(6);
      check("gate_hot", {3'h0, gate_on}, 8'h1e);
      frame(wr(diag_pkg::IDX_HWCFG, 5'h00), 8'h01);
      wclk(8);
      check("gate_keep", {3'h0, gate_on}, 8'h1e);
      frame(wr(diag_pkg::IDX_HWCFG, 5'h01), 8'h01);
      wclk(8);
      check("gate_clr", {3'h0, gate_on}, 8'h1f);
      frame(wr(diag_pkg::IDX_HWCFG, 5'h00), 8'h01);
      frame(wr(diag_pkg::IDX_HWCFG, 5'h00), 8'h00);
      lho_i = 1'b1;
      wclk(6);
      frame(wr(diag_pkg::IDX_HWCFG, 5'h0a), 8'h00);
      frame(rd(diag_pkg::IDX_HWCFG), 8'h00);
      frame(wr(diag_pkg::IDX_HWCFG, 5'h00), 8'h1a);
      results();
   end
endmodule
